/* File: design/ancm_top.sv */
// Operation
// - Strap low: force mode from ability straps
// - Strap high: advertise ability set from straps
// - Strap capture after reset release loads strap decode into advert bits 8:5
// - Control register writes override strap setup
// - Negotiating sends advert register in FLP bursts
// - Resolve common ability by fixed priority
// - Control register enables, disables, restarts negotiation
// - Forced mode takes speed and duplex bits
// - Negotiation enabled ignores speed and duplex bits
// - PHY status shows speed after link
// - Status reads constant abilities, no T4
// - Status shows complete, fault, link, preamble
// - Advertise all by default, writes suppress
// - Capture received page words while negotiating or linked
// - Parallel detect loads fixed partner image
// - Expansion reports fault, next page, received, able
// - Writing restart bit with enable set restarts negotiation
// - Renegotiation halts transmit until break timer expires; a lost link returns to FLP with no break
`timescale 1ns/1ps
`default_nettype none
module ancm_top #(
   parameter int unsigned BREAK_CYCLES = ancm_pkg::BREAK_LINK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic negotiate_strap,
   input wire logic ability_strap_hi,
   input wire logic ability_strap_lo,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic rx_page_strobe,
   input wire logic [15:0] rx_page_word,
   input wire logic rx_link100,
   input wire logic rx_link10,
   output logic flp_tx_en,
   output logic [15:0] flp_tx_word,
   output logic tx_halt,
   output ancm_pkg::ancm_mode_t link_mode,
   output logic link_up
);
   ancm_pkg::ancm_state_t state_q, state_d;
   logic [21:0] pin_s1_q, pin_s2_q;
   logic strobe_s3_q;
   logic [1:0] strap_cnt_q;
   logic [15:0] ctrl_q, ctrl_d, adv_q, adv_d, lpa_q, lpa_d;
   logic exp_pr_q, lpan_q, pdf_q, an_done_q;
   logic s_neg, s_hi, s_lo, s_strobe, s_l100, s_l10;
   logic [15:0] s_word;
   logic strap_take, page_evt, ctrl_wr, adv_wr, exp_rd, break_start, an_off;
   logic negotiating, pd100, pd10, pd_done, pd_fault, page_done, link_now, tmr_done;
   logic [3:0] strap_abl, common;
   ancm_pkg::ancm_mode_t res_mode, mode_d;
   logic [15:0] stat_word, exp_word, phys_word, rd_word;

   // Straps and cable-side signals all come from outside this clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 22'h000000;
         pin_s2_q <= 22'h000000;
         strobe_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= {negotiate_strap, ability_strap_hi, ability_strap_lo, rx_page_strobe,
                      rx_page_word, rx_link100, rx_link10};
         pin_s2_q <= pin_s1_q;
         strobe_s3_q <= pin_s2_q[18];
      end
   end

   assign s_neg = pin_s2_q[21];
   assign s_hi = pin_s2_q[20];
   assign s_lo = pin_s2_q[19];
   assign s_strobe = pin_s2_q[18];
   assign s_word = pin_s2_q[17:2];
   assign s_l100 = pin_s2_q[1];
   assign s_l10 = pin_s2_q[0];

   // Straps are caught once the synchroniser has filled after reset release
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strap_cnt_q <= 2'h0;
      end else if (state_q == ancm_pkg::ST_STRAP && !strap_take) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   assign strap_take = (state_q == ancm_pkg::ST_STRAP) && (strap_cnt_q == ancm_pkg::STRAP_WAIT);

   // Strap decode: forced modes give one ability, advertised modes a set
   assign strap_abl = s_neg ? {s_lo, s_hi | s_lo, ~(s_hi ^ s_lo), ~s_lo | s_hi}
                            : {s_hi & s_lo, s_hi & ~s_lo, ~s_hi & s_lo, ~s_hi & ~s_lo};

   // Bus decode
   assign ctrl_wr = reg_wr && (reg_addr == ancm_pkg::ADDR_CTRL) && (state_q != ancm_pkg::ST_STRAP);
   assign adv_wr = reg_wr && (reg_addr == ancm_pkg::ADDR_ADV);
   assign exp_rd = reg_rd && (reg_addr == ancm_pkg::ADDR_EXP);
   assign an_off = ctrl_wr && !reg_wdata[ancm_pkg::CTL_NEGOTIATE_STRAP];
   // Enable must see a 0 to 1 edge, or restart with enable kept set
   assign break_start = ctrl_wr && reg_wdata[ancm_pkg::CTL_NEGOTIATE_STRAP]
                        && (reg_wdata[ancm_pkg::CTL_RESTART] || !ctrl_q[ancm_pkg::CTL_NEGOTIATE_STRAP]);

   // Partner pages are accepted during a negotiation and after, for next pages
   assign negotiating = (state_q == ancm_pkg::ST_FLP);
   assign page_evt = s_strobe && !strobe_s3_q
                     && (negotiating || state_q == ancm_pkg::ST_LINKED);
   assign pd_fault = negotiating && !lpan_q && s_l100 && s_l10;
   assign pd100 = negotiating && !lpan_q && s_l100 && !s_l10;
   assign pd10 = negotiating && !lpan_q && s_l10 && !s_l100;
   assign pd_done = pd100 || pd10;
   assign common = adv_q[ancm_pkg::ABL_HI:ancm_pkg::ABL_LO] & lpa_q[ancm_pkg::ABL_HI:ancm_pkg::ABL_LO];
   assign page_done = negotiating && lpan_q && !page_evt && (common != 4'h0);

   // Highest shared ability wins; 100 full down to 10 half
   assign res_mode.speed100 = common[3] || common[2];
   assign res_mode.full = common[3] || (!common[2] && common[1]);
   assign link_now = link_mode.speed100 ? s_l100 : s_l10;

   // Control register: software may change the strap choice once the straps are taken
   always_comb begin
      ctrl_d = ctrl_q;
      if (strap_take) begin
         ctrl_d = ancm_pkg::CTRL_RESET;
         ctrl_d[ancm_pkg::CTL_NEGOTIATE_STRAP] = s_neg;
         ctrl_d[ancm_pkg::CTL_SPEED] = s_hi;
         ctrl_d[ancm_pkg::CTL_DUPLEX] = s_lo;
      end else if (ctrl_wr) begin
         ctrl_d = reg_wdata & ancm_pkg::CTRL_WMASK;
      end
   end

   // Advert register: reset image has every ability, straps then trim it
   always_comb begin
      adv_d = adv_q;
      if (strap_take) begin
         adv_d[ancm_pkg::ABL_HI:ancm_pkg::ABL_LO] = strap_abl;
      end else if (adv_wr) begin
         adv_d = (reg_wdata & ancm_pkg::ADV_WMASK) | ancm_pkg::ADV_SELECTOR;
      end
   end

   // Partner register takes base and next pages, or the parallel detect image
   always_comb begin
      lpa_d = lpa_q;
      if (break_start) begin
         lpa_d = ancm_pkg::LPA_RESET;
      end else if (page_evt) begin
         lpa_d = s_word;
      end else if (pd100) begin
         lpa_d = ancm_pkg::LPA_PD100;
      end else if (pd10) begin
         lpa_d = ancm_pkg::LPA_PD10;
      end
   end

   // Negotiation sequence
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ancm_pkg::ST_STRAP: begin
            if (strap_take) begin
               state_d = s_neg ? ancm_pkg::ST_FLP : ancm_pkg::ST_FORCED;
            end
         end
         ancm_pkg::ST_FORCED: begin
         end
         ancm_pkg::ST_BREAK: begin
            if (tmr_done) begin
               state_d = ancm_pkg::ST_FLP;
            end
         end
         ancm_pkg::ST_FLP: begin
            if (pd_done || page_done) begin
               state_d = ancm_pkg::ST_LINKED;
            end
         end
         ancm_pkg::ST_LINKED: begin
            // Losing the link resumes negotiation without a break
            if (!link_now) begin
               state_d = ancm_pkg::ST_FLP;
            end
         end
      endcase
      if (an_off) begin
         state_d = ancm_pkg::ST_FORCED;
      end else if (break_start) begin
         state_d = ancm_pkg::ST_BREAK;
      end
   end

   // Operating mode: forced bits only count while negotiation is off
   always_comb begin
      mode_d = link_mode;
      if (state_q == ancm_pkg::ST_FORCED) begin
         mode_d.speed100 = ctrl_q[ancm_pkg::CTL_SPEED];
         mode_d.full = ctrl_q[ancm_pkg::CTL_DUPLEX];
      end else if (pd_done) begin
         mode_d.speed100 = pd100;
         mode_d.full = 1'b0;
      end else if (page_done) begin
         mode_d = res_mode;
      end
   end

   ancm_break_timer #(
      .CYCLES(BREAK_CYCLES)
   ) u_break_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(break_start),
      .done(tmr_done)
   );

   // State, registers and line outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ancm_pkg::ST_STRAP;
         ctrl_q <= ancm_pkg::CTRL_RESET;
         adv_q <= ancm_pkg::ADV_RESET;
         lpa_q <= ancm_pkg::LPA_RESET;
         link_mode <= '0;
         link_up <= 1'b0;
         flp_tx_en <= 1'b0;
         tx_halt <= 1'b0;
      end else begin
         state_q <= state_d;
         ctrl_q <= ctrl_d;
         adv_q <= adv_d;
         lpa_q <= lpa_d;
         link_mode <= mode_d;
         link_up <= (state_d == ancm_pkg::ST_LINKED)
                    || (state_d == ancm_pkg::ST_FORCED && link_now);
         flp_tx_en <= (state_d == ancm_pkg::ST_FLP);
         tx_halt <= (state_d == ancm_pkg::ST_BREAK);
      end
   end

   assign flp_tx_word = adv_q;

   // Status flags: a set in the same cycle as a clearing read wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         exp_pr_q <= 1'b0;
         lpan_q <= 1'b0;
         pdf_q <= 1'b0;
         an_done_q <= 1'b0;
      end else begin
         exp_pr_q <= page_evt || (exp_pr_q && !exp_rd);
         pdf_q <= pd_fault || (pdf_q && !exp_rd);
         lpan_q <= page_evt || (lpan_q && !break_start && state_d != ancm_pkg::ST_FORCED);
         an_done_q <= (state_d == ancm_pkg::ST_LINKED);
      end
   end

   // Read images
   assign stat_word = ancm_pkg::STAT_CONST
                      | ({15'h0000, an_done_q} << ancm_pkg::STAT_ANC)
                      | ({15'h0000, lpa_q[ancm_pkg::LP_REMOTE_FAULT]} << ancm_pkg::STAT_RF)
                      | ({15'h0000, link_up} << ancm_pkg::STAT_LINK);
   assign exp_word = ({15'h0000, pdf_q} << ancm_pkg::EXP_PDF)
                     | ({15'h0000, lpa_q[ancm_pkg::LP_NEXT_PAGE]} << ancm_pkg::EXP_LPNP)
                     | ({15'h0000, ancm_pkg::LOCAL_NP_ABLE} << ancm_pkg::EXP_NP)
                     | ({15'h0000, exp_pr_q} << ancm_pkg::EXP_PR)
                     | ({15'h0000, lpan_q} << ancm_pkg::EXP_LPAN);
   assign phys_word = ({15'h0000, link_up} << ancm_pkg::PHYS_LINK)
                      | ({15'h0000, link_up & ~link_mode.speed100} << ancm_pkg::PHYS_SPD10)
                      | ({15'h0000, link_up & link_mode.full} << ancm_pkg::PHYS_DUP)
                      | ({15'h0000, an_done_q} << ancm_pkg::PHYS_ANC);
   assign rd_word = (reg_addr == ancm_pkg::ADDR_CTRL) ? ctrl_q :
                    (reg_addr == ancm_pkg::ADDR_STAT) ? stat_word :
                    (reg_addr == ancm_pkg::ADDR_ADV) ? adv_q :
                    (reg_addr == ancm_pkg::ADDR_LPA) ? lpa_q :
                    (reg_addr == ancm_pkg::ADDR_EXP) ? exp_word :
                    (reg_addr == ancm_pkg::ADDR_PHYS) ? phys_word : 16'h0000;

   // Read data is held until the next read; unmapped offsets give zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_word;
         end
      end
   end

   property p_strap_forced;
      @(posedge mclk) disable iff (!rst_n)
      (strap_take && !s_neg) |-> ##2 (link_mode == {$past(s_hi, 2), $past(s_lo, 2)});
   endproperty
   a_strap_forced: assert property (p_strap_forced) else $error("forced strap mode wrong");

   property p_strap_advert;
      @(posedge mclk) disable iff (!rst_n)
      (strap_take && s_neg && s_hi && !s_lo) |=> (adv_q[ancm_pkg::ABL_HI:ancm_pkg::ABL_LO] == 4'h5)
         && flp_tx_en;
   endproperty
   a_strap_advert: assert property (p_strap_advert) else $error("strap advert set wrong");

   property p_strap_load;
      @(posedge mclk) disable iff (!rst_n)
      strap_take |=> adv_q[ancm_pkg::ABL_HI:ancm_pkg::ABL_LO] == $past(strap_abl);
   endproperty
   a_strap_load: assert property (p_strap_load) else $error("strap not loaded into advert");

   property p_an_off;
      @(posedge mclk) disable iff (!rst_n)
      an_off |=> (state_q == ancm_pkg::ST_FORCED) ##1 !flp_tx_en;
   endproperty
   a_an_off: assert property (p_an_off) else $error("disable did not force mode");

   property p_break_halt;
      @(posedge mclk) disable iff (!rst_n)
      break_start |=> (tx_halt && !flp_tx_en) [*8];
   endproperty
   a_break_halt: assert property (p_break_halt) else $error("transmit not halted in break");

   property p_restart;
      @(posedge mclk) disable iff (!rst_n)
      break_start |=> (state_q == ancm_pkg::ST_BREAK) && !an_done_q;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not taken");

   property p_priority;
      @(posedge mclk) disable iff (!rst_n)
      (page_done && !an_off && !break_start && common[3]) |=> link_mode == 2'h3 ##1 link_up;
   endproperty
   a_priority: assert property (p_priority) else $error("top priority not chosen");

   property p_forced_bits;
      @(posedge mclk) disable iff (!rst_n)
      (state_q == ancm_pkg::ST_FORCED && $stable(ctrl_q) && !$past(strap_take))
         |-> link_mode == {ctrl_q[ancm_pkg::CTL_SPEED], ctrl_q[ancm_pkg::CTL_DUPLEX]};
   endproperty
   a_forced_bits: assert property (p_forced_bits) else $error("forced mode ignores bits");

   property p_pd_image;
      @(posedge mclk) disable iff (!rst_n)
      (pd100 && !page_evt && !break_start) |=> lpa_q == ancm_pkg::LPA_PD100 && !lpan_q;
   endproperty
   a_pd_image: assert property (p_pd_image) else $error("parallel detect image wrong");

   property p_page_cap;
      @(posedge mclk) disable iff (!rst_n)
      (page_evt && !break_start) |=> lpa_q == $past(s_word) && exp_pr_q;
   endproperty
   a_page_cap: assert property (p_page_cap) else $error("page word not captured");

   property p_stat_const;
      @(posedge mclk) disable iff (!rst_n)
      (reg_rd && reg_addr == ancm_pkg::ADDR_STAT)
         |=> reg_rvalid && ((reg_rdata & ancm_pkg::STAT_CONST) == ancm_pkg::STAT_CONST)
             && !reg_rdata[15];
   endproperty
   a_stat_const: assert property (p_stat_const) else $error("status constant bits wrong");
endmodule
`default_nettype wire

/* File: design/ancm_pkg.sv */
package ancm_pkg;
   // Register offsets on the management port
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_STAT = 5'h01;
   localparam logic [4:0] ADDR_ADV = 5'h04;
   localparam logic [4:0] ADDR_LPA = 5'h05;
   localparam logic [4:0] ADDR_EXP = 5'h06;
   localparam logic [4:0] ADDR_PHYS = 5'h10;

   // Control register fields
   localparam int CTL_SPEED = 13;
   localparam int CTL_NEGOTIATE_STRAP = 12;
   localparam int CTL_RESTART = 9;
   localparam int CTL_DUPLEX = 8;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'h3100;

   // Ability field, top bit first: 100 full, 100 half, 10 full, 10 half
   localparam int ABL_HI = 8;
   localparam int ABL_LO = 5;
   localparam logic [15:0] ADV_RESET = 16'h01E1;
   localparam logic [15:0] ADV_WMASK = 16'hFFE0;
   localparam logic [15:0] ADV_SELECTOR = 16'h0001;

   // Partner word fields and parallel detect images
   localparam int LP_NEXT_PAGE = 15;
   localparam int LP_REMOTE_FAULT = 13;
   localparam logic [15:0] LPA_RESET = 16'h0000;
   localparam logic [15:0] LPA_PD100 = 16'h0081;
   localparam logic [15:0] LPA_PD10 = 16'h0021;

   // Status register: fixed abilities, then live bits
   localparam logic [15:0] STAT_CONST = 16'h7849;
   localparam int STAT_ANC = 5;
   localparam int STAT_RF = 4;
   localparam int STAT_LINK = 2;

   // Expansion register fields
   localparam int EXP_PDF = 4;
   localparam int EXP_LPNP = 3;
   localparam int EXP_NP = 2;
   localparam int EXP_PR = 1;
   localparam int EXP_LPAN = 0;
   localparam logic LOCAL_NP_ABLE = 1'b0;

   // PHY status summary fields
   localparam int PHYS_LINK = 0;
   localparam int PHYS_SPD10 = 1;
   localparam int PHYS_DUP = 2;
   localparam int PHYS_ANC = 4;

   // Cycles after reset release before the synchronised straps are trusted
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   // Timing
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned BREAK_LINK_MS = 1500;
   localparam int unsigned BREAK_LINK_CYCLES = BREAK_LINK_MS * 1000 * CLK_MHZ;

   typedef enum logic [4:0] {
      ST_STRAP = 5'h01,
      ST_FORCED = 5'h02,
      ST_BREAK = 5'h04,
      ST_FLP = 5'h08,
      ST_LINKED = 5'h10
   } ancm_state_t;

   typedef struct packed {
      logic speed100;
      logic full;
   } ancm_mode_t;
endpackage

/* File: design/ancm_break_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ancm_break_timer #(
   parameter int unsigned CYCLES = ancm_pkg::BREAK_LINK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic start,
   output logic done
);
   logic [31:0] cnt_q;
   logic busy_q;
   logic last;

   // A new start reloads the count, so a restart during a break lengthens it
   assign last = busy_q && (cnt_q == 32'h0000_0001);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 32'h0000_0000;
         busy_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= last && !start;
         if (start) begin
            cnt_q <= CYCLES;
            busy_q <= 1'b1;
         end else if (last) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 32'h0000_0001;
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/ancm_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// Remote link partner: one base page on request, or a steady receive link level
module ancm_link_partner (
   input wire logic mclk,
   output logic rx_page_strobe,
   output logic [15:0] rx_page_word,
   output logic rx_link100,
   output logic rx_link10
);
   initial begin
      rx_page_strobe = 1'b0;
      rx_page_word = 16'h0000;
      rx_link100 = 1'b0;
      rx_link10 = 1'b0;
   end

   // Word settles before the strobe edge and holds well past the synchroniser;
   // afterwards it is inverted so a stale word can never be mistaken for a page
   task automatic send_page(input logic [15:0] w, input logic l100, input logic l10);
      @(posedge mclk);
      rx_page_word <= w;
      repeat (3) @(posedge mclk);
      rx_page_strobe <= 1'b1;
      // Link level trails the strobe by one cycle: the page is taken first,
      // so the level is never mistaken for parallel detect, yet it is up
      // by the time the resolved mode looks for it
      @(posedge mclk);
      rx_link100 <= l100;
      rx_link10 <= l10;
      repeat (3) @(posedge mclk);
      rx_page_strobe <= 1'b0;
      repeat (4) @(posedge mclk);
      rx_page_word <= ~w;
   endtask

   // Plain link signal from a partner that does not negotiate
   task automatic set_link(input logic l100, input logic l10);
      @(posedge mclk);
      rx_link100 <= l100;
      rx_link10 <= l10;
   endtask
endmodule
`default_nettype wire

/* File: dv/autoneg_config_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module autoneg_config_control_tb;
   // Short break timer keeps each restart to a few dozen cycles
   localparam int BRK = 20;
   logic mclk;
   logic rst_n;
   logic negotiate_strap;
   logic ability_strap_hi;
   logic ability_strap_lo;
   logic reg_wr;
   logic reg_rd;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic rx_page_strobe;
   logic [15:0] rx_page_word;
   logic rx_link100;
   logic rx_link10;
   logic flp_tx_en;
   logic [15:0] flp_tx_word;
   logic tx_halt;
   ancm_pkg::ancm_mode_t link_mode;
   logic link_up;
   int err_count;
   int samples_checked;

   ancm_top #(.BREAK_CYCLES(BRK)) i_ancm_top (.mclk(mclk), .rst_n(rst_n),
      .negotiate_strap(negotiate_strap), .ability_strap_hi(ability_strap_hi),
      .ability_strap_lo(ability_strap_lo), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .rx_page_strobe(rx_page_strobe), .rx_page_word(rx_page_word),
      .rx_link100(rx_link100), .rx_link10(rx_link10), .flp_tx_en(flp_tx_en),
      .flp_tx_word(flp_tx_word), .tx_halt(tx_halt), .link_mode(link_mode), .link_up(link_up));

   ancm_link_partner i_ancm_link_partner (.mclk(mclk), .rx_page_strobe(rx_page_strobe),
      .rx_page_word(rx_page_word), .rx_link100(rx_link100), .rx_link10(rx_link10));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Answer is due exactly one cycle after the read is taken
   task automatic reg_check(input logic [4:0] a, input logic [15:0] exp, input string what);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check({what, " rvalid"}, 16'h0001, {15'h0000, reg_rvalid});
      check(what, exp, reg_rdata);
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   task automatic wait_link();
      int n;
      n = 0;
      while (link_up !== 1'b1 && n < 40) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("link_up", 16'h0001, {15'h0000, link_up});
   endtask

   task automatic restart();
      int n;
      reg_write(ancm_pkg::ADDR_CTRL, 16'h1200);
      // Partner drops its link during the break so the next attempt starts clean
      i_ancm_link_partner.set_link(1'b0, 1'b0);
      n = 0;
      while (flp_tx_en !== 1'b1 && n < BRK + 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("flp_tx_en after restart", 16'h0001, {15'h0000, flp_tx_en});
   endtask

   task automatic apply_reset(input logic [2:0] s);
      @(posedge mclk);
      rst_n <= 1'b0;
      {negotiate_strap, ability_strap_hi, ability_strap_lo} <= s;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask

   task automatic strap_scan();
      logic [3:0] nib [8];
      nib = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'h5, 4'hF};
      // Descending, so the run continues from forced 10 Mb/s half duplex
      for (int s = 7; s >= 0; s--) begin
         apply_reset(s[2:0]);
         reg_check(ancm_pkg::ADDR_ADV, {7'h00, nib[s], 5'h01}, "advert");
         check("flp_tx_en", {15'h0000, s[2]}, {15'h0000, flp_tx_en});
         if (s < 4) begin
            check("forced link_mode", {14'h0000, s[1:0]}, {14'h0000, link_mode});
         end
      end
      $display("strap_scan done");
   endtask

   task automatic status_regs();
      reg_check(ancm_pkg::ADDR_STAT, 16'h7849, "status");
      reg_write(ancm_pkg::ADDR_STAT, 16'hFFFF);
      reg_write(ancm_pkg::ADDR_LPA, 16'hFFFF);
      reg_check(ancm_pkg::ADDR_STAT, 16'h7849, "status after write");
      reg_check(ancm_pkg::ADDR_LPA, 16'h0000, "partner after write");
      reg_check(5'h1F, 16'h0000, "unmapped");
      $display("status_regs done");
   endtask

   task automatic forced_control();
      reg_write(ancm_pkg::ADDR_CTRL, 16'h2000);
      settle();
      check("link_mode 100 half", 16'h0002, {14'h0000, link_mode});
      reg_write(ancm_pkg::ADDR_CTRL, 16'h0100);
      settle();
      check("link_mode 10 full", 16'h0001, {14'h0000, link_mode});
      reg_check(ancm_pkg::ADDR_CTRL, 16'h0100, "control");
      $display("forced_control done");
   endtask

   task automatic enable_negotiation();
      int n;
      reg_write(ancm_pkg::ADDR_CTRL, 16'h1000);
      @(posedge mclk);
      #1;
      check("tx_halt in break", 16'h0001, {15'h0000, tx_halt});
      check("flp_tx_en in break", 16'h0000, {15'h0000, flp_tx_en});
      n = 0;
      while (flp_tx_en !== 1'b1 && n < BRK + 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("break length", 16'h0001, {15'h0000, n >= BRK - 1 && n <= BRK + 3});
      check("tx_halt after break", 16'h0000, {15'h0000, tx_halt});
      check("flp_tx_word", 16'h0021, flp_tx_word);
      reg_check(ancm_pkg::ADDR_CTRL, 16'h1000, "control");
      $display("enable_negotiation done");
   endtask

   task automatic advert_resolve();
      reg_write(ancm_pkg::ADDR_ADV, 16'h00C1);
      reg_check(ancm_pkg::ADDR_ADV, 16'h00C1, "advert");
      check("flp_tx_word", 16'h00C1, flp_tx_word);
      // Duplex set and speed clear while negotiating must not steer the mode
      reg_write(ancm_pkg::ADDR_CTRL, 16'h1100);
      i_ancm_link_partner.send_page(16'h21E1, 1'b1, 1'b0);
      wait_link();
      check("negotiated mode", 16'h0002, {14'h0000, link_mode});
      reg_check(ancm_pkg::ADDR_LPA, 16'h21E1, "partner");
      reg_check(ancm_pkg::ADDR_STAT, 16'h787D, "status linked");
      reg_check(ancm_pkg::ADDR_PHYS, 16'h0011, "phy status");
      reg_check(ancm_pkg::ADDR_EXP, 16'h0003, "expansion");
      reg_check(ancm_pkg::ADDR_EXP, 16'h0001, "expansion reread");
      $display("advert_resolve done");
   endtask

   task automatic priority_table();
      logic [15:0] pw [4];
      pw = '{16'h01E1, 16'h00E1, 16'h0061, 16'h0021};
      reg_write(ancm_pkg::ADDR_ADV, 16'h01E1);
      for (int i = 0; i < 4; i++) begin
         restart();
         i_ancm_link_partner.send_page(pw[i], i < 2, i >= 2);
         wait_link();
         check("priority mode", 16'(3 - i), {14'h0000, link_mode});
      end
      $display("priority_table done");
   endtask

   task automatic parallel_detect();
      for (int k = 0; k < 2; k++) begin
         restart();
         i_ancm_link_partner.set_link(k == 0, k == 1);
         wait_link();
         check("pd mode", {14'h0000, k == 0, 1'b0}, {14'h0000, link_mode});
         reg_check(ancm_pkg::ADDR_LPA, (k == 0) ? 16'h0081 : 16'h0021, "pd partner");
         // Page-received from the priority pages stands until the first read
         reg_check(ancm_pkg::ADDR_EXP, (k == 0) ? 16'h0002 : 16'h0000, "pd expansion");
         i_ancm_link_partner.set_link(1'b0, 1'b0);
      end
      restart();
      i_ancm_link_partner.set_link(1'b1, 1'b1);
      repeat (12) @(posedge mclk);
      reg_check(ancm_pkg::ADDR_EXP, 16'h0010, "pd fault");
      i_ancm_link_partner.set_link(1'b0, 1'b0);
      $display("parallel_detect done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Whole run is near five hundred cycles; this cuts a hang well after that
   initial begin
      repeat (8000) @(posedge mclk);
      $display("watchdog expired");
      err_count++;
      tally_and_finish();
   end

   initial begin
      err_count = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      negotiate_strap = 1'b0;
      ability_strap_hi = 1'b0;
      ability_strap_lo = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      strap_scan();
      status_regs();
      forced_control();
      enable_negotiation();
      advert_resolve();
      priority_table();
      parallel_detect();
      tally_and_finish();
   end
endmodule
`default_nettype wire
